// ===== hdl/dmc_arb.sv
// Channel arbiter: controller first, then level, then lowest number
`timescale 1ns/1ps
module dmc_arb #(
  parameter int NCH = 12,
  parameter int NFIRST = 7
) (
  input wire logic [NCH-1:0] pend,
  input wire logic [2*NCH-1:0] level,
  output logic gnt_v,
  output logic [3:0] gnt_idx
);
  // Grant index is four bits wide
  if (NCH < 1 || NCH > 16 || NFIRST < 0 || NFIRST > NCH) begin : g_bad
    $error("dmc_arb: channel counts out of range");
  end
  logic [2:0] best;
  logic [2:0] key;
  always_comb begin
    best = 3'h0;
    key = 3'h0;
    gnt_v = 1'b0;
    gnt_idx = 4'h0;
    // Downward scan with >= lets the lower number win a tie
    for (int i = NCH - 1; i >= 0; i--) begin
      key = {(i < NFIRST), level[2*i +: 2]};
      if (pend[i] && (!gnt_v || key >= best)) begin
        best = key;
        gnt_v = 1'b1;
        gnt_idx = 4'(i);
      end
    end
  end
endmodule

// ===== hdl/dmc_pkg.sv
// Shared constants and types of the multi-channel transfer engine
package dmc_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH = 12;
  localparam int NUM_FIRST = 7;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 16;
  localparam int CTRL_W = 16;
  // ****************************************
  // Register map: one block of words per channel
  // ****************************************
  localparam int CH_SHIFT = 5;
  localparam int REG_SHIFT = 2;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_CNT = 3'h1;
  localparam logic [2:0] REG_PBASE = 3'h2;
  localparam logic [2:0] REG_MBASE = 3'h3;
  localparam logic [2:0] REG_FLAGS = 3'h4;
  localparam int FLG_TC = 0;
  localparam int FLG_HT = 1;
  localparam int FLG_TE = 2;
  localparam int FLG_SWREQ = 3;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [2:0] FLG_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Item sizes
  // ****************************************
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic sw_trig_sel;
    logic mem_to_mem_select;
    logic [1:0] channel_priority_level;
    logic [1:0] mem_item_size;
    logic [1:0] periph_item_size;
    logic mem_ptr_increment;
    logic periph_ptr_increment;
    logic circular_enable;
    logic dir_from_mem;
    logic transfer_error_irq_en;
    logic half_transfer_irq_en;
    logic transfer_complete_irq_en;
    logic en;
  } dmc_ctrl_t;
  localparam dmc_ctrl_t CTRL_RST = 16'h0000;
  typedef struct packed {
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmc_bus_req_t;
  localparam dmc_bus_req_t REQ_RST = 67'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR, ST_ACK} dmc_state_t;
endpackage

// ===== hdl/dmc_top.sv
// Multi-channel transfer engine with AXI4-Lite registers
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module dmc_top #(
  parameter int NCH = dmc_pkg::NUM_CH,
  parameter int NFIRST = dmc_pkg::NUM_FIRST
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dmc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [dmc_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic [NCH-1:0] periph_req,
  output logic [NCH-1:0] periph_ack,
  output logic [NCH-1:0] chan_irq,
  output logic bus_valid,
  output dmc_pkg::dmc_bus_req_t bus_req,
  input wire logic bus_done,
  input wire logic bus_err,
  input wire logic [31:0] bus_rdata
);
  if (NCH < 1 || NCH > 16 || NFIRST < 0 || NFIRST > NCH) begin : g_bad
    $error("dmc_top: channel counts out of range");
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] size_inc(input logic [1:0] s);
    size_inc = (s == dmc_pkg::SZ_BYTE) ? 32'h1 : (s == dmc_pkg::SZ_HALF) ? 32'h2 : 32'h4;
  endfunction
  function automatic logic [31:0] size_mask(input logic [1:0] s, input logic [31:0] d);
    size_mask = (s == dmc_pkg::SZ_BYTE) ? {24'h0, d[7:0]} :
                (s == dmc_pkg::SZ_HALF) ? {16'h0, d[15:0]} : d;
  endfunction
  // Narrow writes repeat the item on every lane for slaves that ignore size
  function automatic logic [31:0] size_dup(input logic [1:0] s, input logic [31:0] d);
    size_dup = (s == dmc_pkg::SZ_BYTE) ? {4{d[7:0]}} :
               (s == dmc_pkg::SZ_HALF) ? {2{d[15:0]}} : d;
  endfunction
  // ****************************************
  // State
  // ****************************************
  dmc_pkg::dmc_ctrl_t ctrl_r [NCH];
  dmc_pkg::dmc_ctrl_t ctrl_nxt [NCH];
  logic [31:0] pbase_r [NCH];
  logic [31:0] pbase_nxt [NCH];
  logic [31:0] mbase_r [NCH];
  logic [31:0] mbase_nxt [NCH];
  logic [31:0] pptr_r [NCH];
  logic [31:0] pptr_nxt [NCH];
  logic [31:0] mptr_r [NCH];
  logic [31:0] mptr_nxt [NCH];
  logic [15:0] cnt_r [NCH];
  logic [15:0] cnt_nxt [NCH];
  logic [15:0] init_r [NCH];
  logic [15:0] init_nxt [NCH];
  logic [2:0] flg_r [NCH];
  logic [2:0] flg_nxt [NCH];
  logic [2:0] fset [NCH];
  logic [2:0] fclr [NCH];
  logic [NCH-1:0] swp_r, swp_nxt, ack_r, ack_nxt, pend;
  logic [2*NCH-1:0] level;
  dmc_pkg::dmc_state_t st_r, st_nxt;
  logic [3:0] cur_r, cur_nxt, gnt_idx, wch, rch;
  logic [31:0] dat_r, dat_nxt, wmask, wd, rd_nxt;
  dmc_pkg::dmc_bus_req_t req_r, req_nxt;
  logic reqv_r, reqv_nxt, gnt_v, wr_go, wr_hit, rd_hit;
  logic awv_r, awv_nxt, wv_r, wv_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [dmc_pkg::ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
  logic [3:0] wstb_r, wstb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [2:0] wreg, rreg;
  logic [15:0] nleft;
  logic src_mem, need_ack;
  dmc_pkg::dmc_ctrl_t newc, cc;
  // ****************************************
  // Arbitration and interrupt lines
  // ****************************************
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign pend[i] = (st_r == dmc_pkg::ST_IDLE) && ctrl_r[i].en && (cnt_r[i] != 16'h0) &&
                     (ctrl_r[i].mem_to_mem_select ||
                      (ctrl_r[i].sw_trig_sel ? swp_r[i] : (periph_req[i] && !ack_r[i])));
    assign level[2*i +: 2] = ctrl_r[i].channel_priority_level;
    assign chan_irq[i] = |(flg_r[i] & {ctrl_r[i].transfer_error_irq_en,
                                       ctrl_r[i].half_transfer_irq_en,
                                       ctrl_r[i].transfer_complete_irq_en});
  end
  dmc_arb #(.NCH(NCH), .NFIRST(NFIRST)) u_arb (
    .pend(pend),
    .level(level),
    .gnt_v(gnt_v),
    .gnt_idx(gnt_idx)
  );
  // ****************************************
  // AXI4-Lite handshake
  // ****************************************
  assign wr_go = awv_r && wv_r && !bv_r;
  assign wch = 4'(awa_r >> dmc_pkg::CH_SHIFT);
  assign wreg = 3'(awa_r >> dmc_pkg::REG_SHIFT);
  assign rch = 4'(s_axi_araddr >> dmc_pkg::CH_SHIFT);
  assign rreg = 3'(s_axi_araddr >> dmc_pkg::REG_SHIFT);
  assign wr_hit = (32'(wch) < NCH) && (wreg <= dmc_pkg::REG_FLAGS);
  assign rd_hit = (32'(rch) < NCH) && (rreg <= dmc_pkg::REG_FLAGS);
  assign wmask = {{8{wstb_r[3]}}, {8{wstb_r[2]}}, {8{wstb_r[1]}}, {8{wstb_r[0]}}};
  always_comb begin
    awv_nxt = awv_r;
    awa_nxt = awa_r;
    wv_nxt = wv_r;
    wdat_nxt = wdat_r;
    wstb_nxt = wstb_r;
    bv_nxt = bv_r;
    bresp_nxt = bresp_r;
    rv_nxt = rv_r;
    rdat_nxt = rdat_r;
    rresp_nxt = rresp_r;
    rd_nxt = 32'h0;
    if (s_axi_awvalid && !awv_r) begin
      awv_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wv_r) begin
      wv_nxt = 1'b1;
      wdat_nxt = s_axi_wdata;
      wstb_nxt = s_axi_wstrb;
    end
    if (wr_go) begin
      awv_nxt = 1'b0;
      wv_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = wr_hit ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
    end else if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    // Current pointers have no read path at all
    if (rreg == dmc_pkg::REG_CTRL) begin
      rd_nxt = 32'(ctrl_r[rch]);
    end else if (rreg == dmc_pkg::REG_CNT) begin
      rd_nxt = 32'(cnt_r[rch]);
    end else if (rreg == dmc_pkg::REG_PBASE) begin
      rd_nxt = pbase_r[rch];
    end else if (rreg == dmc_pkg::REG_MBASE) begin
      rd_nxt = mbase_r[rch];
    end else if (rreg == dmc_pkg::REG_FLAGS) begin
      rd_nxt = {28'h0, swp_r[rch], flg_r[rch]};
    end
    if (s_axi_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rdat_nxt = rd_hit ? rd_nxt : 32'h0;
      rresp_nxt = rd_hit ? dmc_pkg::RESP_OKAY : dmc_pkg::RESP_SLVERR;
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_r <= 1'b0;
      awa_r <= '0;
      wv_r <= 1'b0;
      wdat_r <= dmc_pkg::WORD_RST;
      wstb_r <= 4'h0;
      bv_r <= 1'b0;
      bresp_r <= dmc_pkg::RESP_OKAY;
      rv_r <= 1'b0;
      rdat_r <= dmc_pkg::WORD_RST;
      rresp_r <= dmc_pkg::RESP_OKAY;
    end else begin
      awv_r <= awv_nxt;
      awa_r <= awa_nxt;
      wv_r <= wv_nxt;
      wdat_r <= wdat_nxt;
      wstb_r <= wstb_nxt;
      bv_r <= bv_nxt;
      bresp_r <= bresp_nxt;
      rv_r <= rv_nxt;
      rdat_r <= rdat_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign s_axi_awready = !awv_r;
  assign s_axi_wready = !wv_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rdat_r;
  assign s_axi_rresp = rresp_r;
  // ****************************************
  // Transfer engine and channel registers
  // ****************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    pbase_nxt = pbase_r;
    mbase_nxt = mbase_r;
    pptr_nxt = pptr_r;
    mptr_nxt = mptr_r;
    cnt_nxt = cnt_r;
    init_nxt = init_r;
    swp_nxt = swp_r;
    ack_nxt = ack_r;
    st_nxt = st_r;
    cur_nxt = cur_r;
    dat_nxt = dat_r;
    req_nxt = req_r;
    reqv_nxt = reqv_r;
    for (int i = 0; i < NCH; i++) begin
      fset[i] = 3'h0;
      fclr[i] = 3'h0;
    end
    cc = ctrl_r[cur_r];
    src_mem = cc.dir_from_mem;
    need_ack = !cc.mem_to_mem_select && !cc.sw_trig_sel;
    nleft = cnt_r[cur_r] - 16'h1;
    newc = ctrl_r[wch];
    wd = 32'h0;
    case (st_r)
      dmc_pkg::ST_IDLE: begin
        if (gnt_v) begin
          cur_nxt = gnt_idx;
          swp_nxt[gnt_idx] = 1'b0;
          reqv_nxt = 1'b1;
          req_nxt.we = 1'b0;
          req_nxt.size = ctrl_r[gnt_idx].dir_from_mem ? ctrl_r[gnt_idx].mem_item_size
                                                      : ctrl_r[gnt_idx].periph_item_size;
          req_nxt.addr = ctrl_r[gnt_idx].dir_from_mem ? mptr_r[gnt_idx] : pptr_r[gnt_idx];
          req_nxt.wdata = 32'h0;
          st_nxt = dmc_pkg::ST_RD;
        end
      end
      dmc_pkg::ST_RD: begin
        if (bus_done && bus_err) begin
          fset[cur_r][dmc_pkg::FLG_TE] = 1'b1;
          ctrl_nxt[cur_r].en = 1'b0;
          reqv_nxt = 1'b0;
          st_nxt = dmc_pkg::ST_IDLE;
        end else if (bus_done) begin
          dat_nxt = size_mask(req_r.size, bus_rdata);
          req_nxt.we = 1'b1;
          req_nxt.size = src_mem ? cc.periph_item_size : cc.mem_item_size;
          req_nxt.addr = src_mem ? pptr_r[cur_r] : mptr_r[cur_r];
          req_nxt.wdata = size_dup(src_mem ? cc.periph_item_size : cc.mem_item_size,
                                   size_mask(req_r.size, bus_rdata));
          st_nxt = dmc_pkg::ST_WR;
        end
      end
      dmc_pkg::ST_WR: begin
        if (bus_done) begin
          reqv_nxt = 1'b0;
          st_nxt = dmc_pkg::ST_IDLE;
          if (bus_err) begin
            fset[cur_r][dmc_pkg::FLG_TE] = 1'b1;
            ctrl_nxt[cur_r].en = 1'b0;
          end else begin
            if (cc.periph_ptr_increment) begin
              pptr_nxt[cur_r] = pptr_r[cur_r] + size_inc(cc.periph_item_size);
            end
            if (cc.mem_ptr_increment) begin
              mptr_nxt[cur_r] = mptr_r[cur_r] + size_inc(cc.mem_item_size);
            end
            cnt_nxt[cur_r] = nleft;
            if (nleft <= (init_r[cur_r] >> 1) && cnt_r[cur_r] > (init_r[cur_r] >> 1)) begin
              fset[cur_r][dmc_pkg::FLG_HT] = 1'b1;
            end
            if (nleft == 16'h0) begin
              fset[cur_r][dmc_pkg::FLG_TC] = 1'b1;
              if (cc.circular_enable) begin
                cnt_nxt[cur_r] = init_r[cur_r];
                pptr_nxt[cur_r] = pbase_r[cur_r];
                mptr_nxt[cur_r] = mbase_r[cur_r];
              end
            end
            if (need_ack) begin
              ack_nxt[cur_r] = 1'b1;
              st_nxt = dmc_pkg::ST_ACK;
            end
          end
        end
      end
      default: begin
        // Peripheral must drop its request before the acknowledge is released
        if (!periph_req[cur_r]) begin
          ack_nxt[cur_r] = 1'b0;
          st_nxt = dmc_pkg::ST_IDLE;
        end
      end
    endcase
    if (wr_go && wr_hit) begin
      if (wreg == dmc_pkg::REG_CTRL) begin
        wd = (32'(ctrl_r[wch]) & ~wmask) | (wdat_r & wmask);
        newc = dmc_pkg::dmc_ctrl_t'(wd[dmc_pkg::CTRL_W-1:0]);
        if (newc.en && !ctrl_r[wch].en) begin
          pptr_nxt[wch] = pbase_r[wch];
          mptr_nxt[wch] = mbase_r[wch];
        end
        ctrl_nxt[wch] = newc;
      end else if (wreg == dmc_pkg::REG_CNT) begin
        wd = (32'(cnt_r[wch]) & ~wmask) | (wdat_r & wmask);
        if (!ctrl_r[wch].en) begin
          cnt_nxt[wch] = wd[dmc_pkg::CNT_W-1:0];
          init_nxt[wch] = wd[dmc_pkg::CNT_W-1:0];
        end
      end else if (wreg == dmc_pkg::REG_PBASE) begin
        pbase_nxt[wch] = (pbase_r[wch] & ~wmask) | (wdat_r & wmask);
      end else if (wreg == dmc_pkg::REG_MBASE) begin
        mbase_nxt[wch] = (mbase_r[wch] & ~wmask) | (wdat_r & wmask);
      end else begin
        fclr[wch] = wdat_r[2:0] & wmask[2:0];
        if (wdat_r[dmc_pkg::FLG_SWREQ] && wstb_r[0]) begin
          swp_nxt[wch] = 1'b1;
        end
      end
    end
    // An event in the cycle of its clear is kept
    for (int i = 0; i < NCH; i++) begin
      flg_nxt[i] = (flg_r[i] & ~fclr[i]) | fset[i];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_r[i] <= dmc_pkg::CTRL_RST;
        pbase_r[i] <= dmc_pkg::WORD_RST;
        mbase_r[i] <= dmc_pkg::WORD_RST;
        pptr_r[i] <= dmc_pkg::WORD_RST;
        mptr_r[i] <= dmc_pkg::WORD_RST;
        cnt_r[i] <= 16'h0000;
        init_r[i] <= 16'h0000;
        flg_r[i] <= dmc_pkg::FLG_RST;
      end
      swp_r <= '0;
      ack_r <= '0;
      st_r <= dmc_pkg::ST_IDLE;
      cur_r <= 4'h0;
      dat_r <= dmc_pkg::WORD_RST;
      req_r <= dmc_pkg::REQ_RST;
      reqv_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      pbase_r <= pbase_nxt;
      mbase_r <= mbase_nxt;
      pptr_r <= pptr_nxt;
      mptr_r <= mptr_nxt;
      cnt_r <= cnt_nxt;
      init_r <= init_nxt;
      flg_r <= flg_nxt;
      swp_r <= swp_nxt;
      ack_r <= ack_nxt;
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      dat_r <= dat_nxt;
      req_r <= req_nxt;
      reqv_r <= reqv_nxt;
    end
  end
  assign periph_ack = ack_r;
  assign bus_valid = reqv_r;
  assign bus_req = req_r;
  // ****************************************
  // Checks
  // ****************************************
  a_ack_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_ACK && periph_req[cur_r]) |=> (st_r == dmc_pkg::ST_ACK && ack_r[$past(cur_r)]))
    else $error("acknowledge released while request high");
  a_count_dec: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_WR && bus_done && !bus_err && cnt_r[cur_r] > 16'h1 && !(wr_go && wr_hit))
    |=> cnt_r[$past(cur_r)] == $past(cnt_r[cur_r]) - 16'h1)
    else $error("count not decremented by one");
  a_zero_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_WR && bus_done && !bus_err && cnt_r[cur_r] == 16'h1 &&
     !ctrl_r[cur_r].circular_enable && !wr_go)
    |=> (cnt_r[$past(cur_r)] == 16'h0 && !pend[$past(cur_r)]))
    else $error("channel still served after its last item");
  a_base_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r != dmc_pkg::ST_IDLE && !wr_go) |=> pbase_r[$past(cur_r)] == $past(pbase_r[cur_r]))
    else $error("base address changed by transfer");
  a_circular_enable_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_WR && bus_done && !bus_err && cnt_r[cur_r] == 16'h1 &&
     ctrl_r[cur_r].circular_enable && !wr_go)
    |=> (cnt_r[$past(cur_r)] == init_r[$past(cur_r)] && mptr_r[$past(cur_r)] == mbase_r[$past(cur_r)]))
    else $error("circular reload missing");
  a_tc_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_WR && bus_done && !bus_err && cnt_r[cur_r] == 16'h1 &&
     ctrl_r[cur_r].transfer_complete_irq_en && !wr_go)
    |=> (flg_r[$past(cur_r)][dmc_pkg::FLG_TC] && chan_irq[$past(cur_r)]))
    else $error("complete flag or interrupt missing");
  a_err_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_RD && bus_done && bus_err && !wr_go)
    |=> (flg_r[$past(cur_r)][dmc_pkg::FLG_TE] && !ctrl_r[$past(cur_r)].en && !bus_valid))
    else $error("error response not flagged");
  a_start_now: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_IDLE && |pend) |=> (st_r == dmc_pkg::ST_RD && bus_valid && !bus_req.we))
    else $error("pending channel not started");
  a_ptr_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == dmc_pkg::ST_WR && bus_done && !bus_err && cnt_r[cur_r] > 16'h1 && !wr_go &&
     ctrl_r[cur_r].periph_ptr_increment && ctrl_r[cur_r].periph_item_size == dmc_pkg::SZ_HALF)
    |=> pptr_r[$past(cur_r)] == $past(pptr_r[cur_r]) + 32'h2)
    else $error("pointer step wrong");
endmodule

// ===== tb/dmc_far_model.sv
// Far-side model: system-bus memory slave and requesting peripherals
`timescale 1ns/1ps
module dmc_far_model #(parameter int NCH = 12) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_valid,
  input wire dmc_pkg::dmc_bus_req_t bus_req,
  output logic bus_done,
  output logic bus_err,
  output logic [31:0] bus_rdata,
  input wire logic [3:0] dly,
  input wire logic err_en,
  input wire logic [NCH-1:0] want,
  input wire logic [NCH-1:0] periph_ack,
  output logic [NCH-1:0] periph_req
);
  logic [3:0] cnt;
  logic [31:0] item;
  int owed [NCH];
  assign item = {bus_req.addr[15:0] ^ 16'h5A3C, bus_req.addr[15:0]};
  // Released data turns over so stale data never passes for a read
  assign bus_rdata = bus_done ? item : ~item;
  assign bus_err = bus_done & err_en;
  always @(posedge aclk) begin
    bus_done <= 1'h0;
    if (!aresetn || bus_done) cnt <= 4'h0;
    else if (bus_valid && cnt >= dly) bus_done <= 1'h1;
    else if (bus_valid) cnt <= cnt + 4'h1;
    for (int i = 0; i < NCH; i++) begin
      owed[i] = !aresetn ? 0 : owed[i] + int'(want[i]);
      // Drop on acknowledge; a new request waits until it is withdrawn
      if (!aresetn || periph_ack[i]) periph_req[i] <= 1'h0;
      else if (!periph_req[i] && owed[i] > 0) begin
        periph_req[i] <= 1'h1;
        owed[i]--;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench of the multi-channel transfer engine
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, err_en = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, bus_rdata, pb;
  logic [3:0] s_axi_wstrb = 4'hF, dly = 4'h0;
  logic [11:0] want = 12'h0, ack_q = 12'h0, periph_req, periph_ack, chan_irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic bus_valid, bus_done, bus_err;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] er;
  logic [63:0] ew;
  dmc_pkg::dmc_bus_req_t bus_req;
  logic [63:0] exp_w[$];
  logic [33:0] exp_r[$];
  int n_mismatch = 0;
  int checks = 0;
  int seed = 55800;
  int ord[4] = '{1, 3, 2, 8};
  logic [1:0] pl[4] = '{2'h3, 2'h3, 2'h0, 2'h3};

  always #20 aclk = ~aclk;
  dmc_top u_dmc_top (.*);
  dmc_far_model u_dmc_far_model (.*);

  // ********
  // Result watcher
  // ********
  always @(posedge aclk) begin
    ack_q <= periph_ack;
    if (aresetn) `CHK("ack", 12'h0, ack_q & ~periph_ack & periph_req)
    if (bus_valid && bus_done && bus_req.we) begin
      ew = exp_w.size() > 0 ? exp_w.pop_front() : 64'hX;
      `CHK("bus write", ew, {bus_req.addr, bus_req.wdata})
    end
    if (s_axi_bvalid && s_axi_bready) begin
      er = exp_r.pop_front();
      `CHK("reg write", er, {s_axi_bresp, 32'h0})
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = exp_r.pop_front();
      `CHK("reg read", er, {s_axi_rresp, s_axi_rdata})
    end
  end

  task wrap_up();
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [11:0] ra(input int ch, input int rg);
    return 12'(ch * 32 + rg * 4);
  endfunction

  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A3C, a[15:0]};
  endfunction

  // One register access; a read notes its expected response and data
  task automatic axi(input logic wr, input logic [11:0] a, input logic [33:0] d);
    logic ta, tw, done;
    @(posedge aclk);
    done = 1'h0;
    exp_r.push_back(wr ? {d[33:32], 32'h0} : d);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d[31:0];
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    for (int i = 0; i < 50 && !done; i++) begin
      @(negedge aclk);
      ta = wr ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
      tw = s_axi_wvalid & s_axi_wready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      @(posedge aclk);
      if (ta && wr) s_axi_awvalid <= 1'h0;
      if (ta && !wr) s_axi_arvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (done) s_axi_bready <= 1'h0;
      if (done) s_axi_rready <= 1'h0;
    end
    if (!done) n_mismatch++;
    if (!done) wrap_up();
  endtask

  task automatic setup(input int ch, input logic [31:0] p, input logic [31:0] m,
                       input logic [15:0] n, input logic [15:0] c);
    axi(1'h1, ra(ch, 2), {2'h0, p});
    axi(1'h1, ra(ch, 3), {2'h0, m});
    axi(1'h1, ra(ch, 1), {18'h0, n});
    axi(1'h1, ra(ch, 0), {18'h0, c});
  endtask

  // Bounded wait for all noted writes and the interrupts in m
  task automatic drain(input logic [11:0] m);
    int i;
    for (i = 0; i < 400 && (exp_w.size() > 0 || bus_valid || (chan_irq & m) != m); i++)
      @(posedge aclk);
    if (i == 400) n_mismatch++;
    if (i == 400) wrap_up();
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    dly <= 4'($random(seed)) & 4'h3;
    pb = $random(seed) & 32'hFFF0;
    axi(1'h0, ra(12, 0), {dmc_pkg::RESP_SLVERR, 32'h0});
    axi(1'h0, ra(11, 0), 34'h0);
    axi(1'h1, ra(12, 0), {dmc_pkg::RESP_SLVERR, 32'h0});
    for (int k = 0; k < 2; k++)
      exp_w.push_back({pb + 32'h1_0000 + 32'(4 * k), pat(pb + 32'(4 * k))});
    setup(0, pb, pb + 32'h1_0000, 16'h2, 16'h4AC7);
    drain(12'h001);
    axi(1'h0, ra(0, 4), 34'h3);
    `CHK("irq", 1'h1, chan_irq[0])
    axi(1'h0, ra(0, 2), {2'h0, pb});
    axi(1'h1, ra(0, 1), 34'h5);
    axi(1'h0, ra(0, 1), 34'h0);
    axi(1'h1, ra(0, 4), 34'h7);
    axi(1'h1, ra(0, 0), 34'h4AC6);
    axi(1'h0, ra(0, 0), 34'h4AC6);
    `CHK("irq", 1'h0, chan_irq[0])
    axi(1'h1, ra(0, 1), 34'h3);
    axi(1'h0, ra(0, 1), 34'h3);
    for (int k = 0; k < 4; k++) begin
      pb = 32'h3000 + 32'(ord[k] * 16);
      exp_w.push_back({pb + 32'h1000, pat(pb)});
      setup(ord[k], pb, pb + 32'h1000, 16'h1, {2'h0, pl[k], 12'hA01});
    end
    @(posedge aclk);
    want <= 12'h10E;
    @(posedge aclk);
    want <= 12'h0;
    drain(12'h0);
    pb = 32'h4000 | ($random(seed) & 32'hFF);
    for (int k = 0; k < 3; k++) begin
      exp_w.push_back({32'h5000 + 32'(k % 2), {4{8'(pb + 32'(k % 2))}}});
    end
    setup(6, pb, 32'h5000, 16'h2, 16'h00E1);
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      want <= 12'h040;
      @(posedge aclk);
      want <= 12'h0;
    end
    drain(12'h0);
    axi(1'h0, ra(6, 1), 34'h1);
    // Memory source, halfword items duplicated on both lanes
    for (int k = 0; k < 2; k++)
      exp_w.push_back({32'h8000 + 32'(2 * k), {2{16'h9000 + 16'(2 * k)}}});
    setup(4, 32'h8000, 32'h9000, 16'h2, 16'h45D1);
    drain(12'h0);
    setup(7, 32'h6000, 32'h7000, 16'h1, 16'h8A01);
    exp_w.push_back({32'h7000, pat(32'h6000)});
    axi(1'h1, ra(7, 4), 34'h8);
    drain(12'h0);
    err_en <= 1'h1;
    setup(5, 32'h6000, 32'h7000, 16'h1, 16'h4A09);
    drain(12'h020);
    axi(1'h0, ra(5, 4), 34'h4);
    wrap_up();
  end
endmodule
